// [pird_pkg.sv]
// Constants and carrier types for the IDE register decode block
package pird_pkg;
    // Address map
    localparam logic [15:0] PRI_CMD_BASE = 16'h01f0;
    localparam logic [15:0] SEC_CMD_BASE = 16'h0170;
    localparam logic [15:0] PRI_CTL_BASE = 16'h03f4;
    localparam logic [15:0] SEC_CTL_BASE = 16'h0374;
    localparam int CMD_SPAN_BITS = 3;
    localparam int CTL_SPAN_BITS = 2;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_DRIVE_HEAD = 3'h6;
    localparam logic [1:0] LANE_ALT_STATUS = 2'h2;
    localparam logic [1:0] LANE_SIDE_BUS = 2'h3;
    localparam int DRIVE_BIT = 4;
    // Timing in PCI clocks
    localparam logic [4:0] CMP_STARTUP = 5'h04;
    localparam logic [4:0] CMP_STROBE = 5'h0b;
    localparam logic [4:0] CMP_RECOVER = 5'h16;
    localparam logic [4:0] CMPD_STARTUP = 5'h03;
    localparam logic [4:0] CMPD_STROBE = 5'h06;
    localparam logic [4:0] CMPD_RECOVER = 5'h0e;
    localparam logic [4:0] ENH_STARTUP = 5'h02;
    localparam logic [4:0] ENH_STROBE_MIN = 5'h02;
    localparam logic [4:0] ENH_RECOVER_MIN = 5'h01;
    localparam logic [4:0] SHUTDOWN = 5'h02;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] be;
        logic write;
        logic [31:0] wdata;
    } pird_req_t;

    typedef struct packed {
        logic time0;
        logic time1;
        logic ie0;
        logic ie1;
        logic sitre;
        logic [1:0] isp;
        logic [1:0] rct;
    } pird_tim_t;

    typedef struct packed {
        logic [1:0] isp;
        logic [1:0] rct;
    } pird_sidtim_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_RECOVER = 3'b011,
        ST_HOLD = 3'b100,
        ST_FINISH = 3'b101
    } pird_state_t;
endpackage

// [pird_decode.sv]
// PCI target decode and PIO cycle engine for one IDE connector
// Function
// - Decode only with I/O space enable and the channel decode enable set.
// - Register access asserts its chip select and runs compatible strobes.
// - Command block is 8 bytes, control block 4 bytes, each own select.
// - Upper 16 address bits must be zero for a hit.
// - Command block base 01F0h primary, 0170h secondary.
// - Control block base 03F4h primary, 0374h secondary.
// - Claim every access in the ranges regardless of byte enables.
// - Primary control block byte 3 goes to the side bus, not the drive.
// - 16-bit access at control offset 2 ends in target abort.
// - Shadow drive/head bit 4 selects the targeted drive.
// - Only data port cycles may use fast timing.
// - Every strobe edge falls on a PCI clock edge.
// - Drive 0 and drive 1 have independent timing selections.
// - Sync DMA drive uses sync timing for DMA, PIO timing otherwise.
// - Secondary ranges are still claimed when enabled.
// - Enhanced strobe 2 to 5 clocks, recovery 1 to 4 clocks.
// - Address and chip selects held 2 clocks after the cycle.
`timescale 1ns/1ps
module pird_decode (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic io_space_enable,
    input wire logic primary_decode_enable,
    input wire logic secondary_decode_enable,
    input wire pird_pkg::pird_tim_t primary_timing_reg,
    input wire pird_pkg::pird_sidtim_t second_drive_timing_reg,
    input wire logic [1:0] sync_dma_control_reg,
    input wire logic [1:0] sync_dma_timing_reg,
    input wire logic req_valid,
    input wire pird_pkg::pird_req_t req,
    output logic req_ready,
    output logic req_claim,
    output logic req_target_abort,
    output logic resp_done,
    output logic [31:0] resp_rdata,
    output logic command_block_select_n,
    output logic control_block_select_n,
    output logic [2:0] drive_addr,
    output logic drive_read_strobe_n,
    output logic drive_write_strobe_n,
    input wire logic [15:0] drive_data_in,
    output logic [15:0] drive_data_out,
    output logic drive_data_oe,
    input wire logic drive_ready_in,
    output logic side_req,
    output logic side_write,
    output logic [7:0] side_wdata,
    input wire logic [7:0] side_rdata,
    output logic drive_select,
    output logic dma_sync_mode,
    output logic [1:0] dma_sync_timing
);
    pird_pkg::pird_state_t state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next, recov_reg, recov_next;
    logic [4:0] strobe_reg, strobe_next;
    logic cmd_cs_reg, cmd_cs_next, ctl_cs_reg, ctl_cs_next;
    logic rd_reg, rd_next, wr_reg, wr_next, oe_reg, oe_next;
    logic [2:0] da_reg, da_next;
    logic [15:0] dout_reg, dout_next;
    logic [1:0] lane_reg, lane_next;
    logic shadow_reg, shadow_next, done_reg, done_next;
    logic [31:0] rdata_reg, rdata_next;
    logic side_reg, side_next, side_wr_reg, side_wr_next;
    logic [7:0] side_wd_reg, side_wd_next;
    logic iordy_wait_reg, iordy_wait_next;
    logic [2:0] rdy_sync;
    logic rdy_reg, rdy_next;
    logic pri_en, sec_en, upper_zero;
    logic pri_cmd, sec_cmd, pri_ctl, sec_ctl, hit, take;
    logic [1:0] low_lane;
    logic [2:0] reg_ofs;
    logic data_port, fast, abort_hit, side_hit;
    logic [1:0] isp_sel, rct_sel;
    logic [4:0] st_cnt, sb_cnt, rc_cnt;
    logic [31:0] wshift;

    assign pri_en = io_space_enable & primary_decode_enable;
    assign sec_en = io_space_enable & secondary_decode_enable;
    assign upper_zero = (req.addr[31:16] == 16'h0000);
    localparam int CMD_SPAN_BITS_L = pird_pkg::CMD_SPAN_BITS;
    localparam int CTL_SPAN_BITS_L = pird_pkg::CTL_SPAN_BITS;
    localparam logic [15:0] PRI_CMD_L = pird_pkg::PRI_CMD_BASE;
    localparam logic [15:0] SEC_CMD_L = pird_pkg::SEC_CMD_BASE;
    localparam logic [15:0] PRI_CTL_L = pird_pkg::PRI_CTL_BASE;
    localparam logic [15:0] SEC_CTL_L = pird_pkg::SEC_CTL_BASE;
    assign pri_cmd = pri_en & upper_zero & (req.addr[15:CMD_SPAN_BITS_L]
        == PRI_CMD_L[15:CMD_SPAN_BITS_L]);
    assign sec_cmd = sec_en & upper_zero & (req.addr[15:CMD_SPAN_BITS_L]
        == SEC_CMD_L[15:CMD_SPAN_BITS_L]);
    assign pri_ctl = pri_en & upper_zero & (req.addr[15:CTL_SPAN_BITS_L]
        == PRI_CTL_L[15:CTL_SPAN_BITS_L]);
    assign sec_ctl = sec_en & upper_zero & (req.addr[15:CTL_SPAN_BITS_L]
        == SEC_CTL_L[15:CTL_SPAN_BITS_L]);

    // Claim any hit, byte enables not needed
    assign hit = pri_cmd | sec_cmd | pri_ctl | sec_ctl;
    assign req_ready = (state_reg == pird_pkg::ST_IDLE);
    assign req_claim = req_valid & req_ready & hit;
    assign take = req_claim;

    always_comb begin
        low_lane = 2'h3;
        if (req.be[0]) begin
            low_lane = 2'h0;
        end else if (req.be[1]) begin
            low_lane = 2'h1;
        end else if (req.be[2]) begin
            low_lane = 2'h2;
        end
    end
    assign reg_ofs = {req.addr[2], low_lane};
    // Word access to alt status aborts
    assign abort_hit = (pri_ctl | sec_ctl) & req.be[2] & req.be[3];
    // Lone byte 3 of primary control block
    assign side_hit = pri_ctl & ~abort_hit
        & (low_lane == pird_pkg::LANE_SIDE_BUS);
    assign req_target_abort = take & abort_hit;
    assign data_port = pri_cmd & (reg_ofs == pird_pkg::OFS_DATA);
    assign wshift = req.wdata >> {low_lane, 3'h0};

    // Per-drive timing selection by shadow bit
    always_comb begin
        isp_sel = primary_timing_reg.isp;
        rct_sel = primary_timing_reg.rct;
        fast = shadow_reg ? primary_timing_reg.time1
                          : primary_timing_reg.time0;
        if (shadow_reg && primary_timing_reg.sitre) begin
            isp_sel = second_drive_timing_reg.isp;
            rct_sel = second_drive_timing_reg.rct;
        end
    end

    // Fast timing only for the data port
    always_comb begin
        if (data_port && fast) begin
            st_cnt = pird_pkg::ENH_STARTUP;
            sb_cnt = pird_pkg::ENH_STROBE_MIN + {3'h0, isp_sel};
            rc_cnt = pird_pkg::ENH_RECOVER_MIN + {3'h0, rct_sel};
        end else if (data_port) begin
            st_cnt = pird_pkg::CMPD_STARTUP;
            sb_cnt = pird_pkg::CMPD_STROBE;
            rc_cnt = pird_pkg::CMPD_RECOVER;
        end else begin
            st_cnt = pird_pkg::CMP_STARTUP;
            sb_cnt = pird_pkg::CMP_STROBE;
            rc_cnt = pird_pkg::CMP_RECOVER;
        end
    end

    // Ready pin synchroniser, change taken when stages 2 and 3 agree
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_sync <= 3'h0;
        end else begin
            rdy_sync <= {rdy_sync[1:0], drive_ready_in};
        end
    end
    assign rdy_next = (rdy_sync[1] == rdy_sync[2]) ? rdy_sync[2] : rdy_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        recov_next = recov_reg;
        strobe_next = strobe_reg;
        cmd_cs_next = cmd_cs_reg;
        ctl_cs_next = ctl_cs_reg;
        rd_next = rd_reg;
        wr_next = wr_reg;
        oe_next = oe_reg;
        da_next = da_reg;
        dout_next = dout_reg;
        lane_next = lane_reg;
        shadow_next = shadow_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        side_next = 1'b0;
        side_wr_next = side_wr_reg;
        side_wd_next = side_wd_reg;
        iordy_wait_next = iordy_wait_reg;
        case (state_reg)
            pird_pkg::ST_IDLE: begin
                if (take) begin
                    rdata_next = 32'h0000_0000;
                    // Shadow updates on command offset 6 write only
                    if (pri_cmd && req.write
                        && reg_ofs == pird_pkg::OFS_DRIVE_HEAD) begin
                        shadow_next = wshift[pird_pkg::DRIVE_BIT];
                    end
                    if (abort_hit) begin
                        state_next = pird_pkg::ST_IDLE;
                    end else if (side_hit) begin
                        side_next = 1'b1;
                        side_wr_next = req.write;
                        side_wd_next = wshift[7:0];
                        state_next = pird_pkg::ST_FINISH;
                    end else if (pri_cmd || (pri_ctl && low_lane
                        == pird_pkg::LANE_ALT_STATUS)) begin
                        cmd_cs_next = pri_cmd;
                        ctl_cs_next = pri_ctl;
                        da_next = reg_ofs;
                        lane_next = low_lane;
                        dout_next = wshift[15:0];
                        oe_next = req.write;
                        wr_next = 1'b0;
                        rd_next = 1'b0;
                        cnt_next = st_cnt;
                        strobe_next = sb_cnt;
                        recov_next = rc_cnt;
                        iordy_wait_next = shadow_reg ? primary_timing_reg.ie1
                                                     : primary_timing_reg.ie0;
                        state_next = pird_pkg::ST_SETUP;
                    end else begin
                        // Secondary or reserved: no connector cycle
                        state_next = pird_pkg::ST_FINISH;
                    end
                end
            end
            pird_pkg::ST_SETUP: begin
                cnt_next = cnt_reg - 5'h01;
                if (cnt_reg == 5'h01) begin
                    // Strobes move on clock edges only
                    rd_next = ~oe_reg;
                    wr_next = oe_reg;
                    cnt_next = strobe_reg;
                    state_next = pird_pkg::ST_STROBE;
                end
            end
            pird_pkg::ST_STROBE: begin
                if (cnt_reg != 5'h01) begin
                    cnt_next = cnt_reg - 5'h01;
                end else if (!iordy_wait_reg || rdy_reg) begin
                    rd_next = 1'b0;
                    wr_next = 1'b0;
                    if (!oe_reg) begin
                        rdata_next = {16'h0000, drive_data_in}
                            << {lane_reg, 3'h0};
                    end
                    cnt_next = recov_reg;
                    state_next = pird_pkg::ST_RECOVER;
                end
            end
            pird_pkg::ST_RECOVER: begin
                cnt_next = cnt_reg - 5'h01;
                if (cnt_reg == 5'h01) begin
                    cnt_next = pird_pkg::SHUTDOWN;
                    state_next = pird_pkg::ST_HOLD;
                end
            end
            pird_pkg::ST_HOLD: begin
                // Address and select held through shutdown
                cnt_next = cnt_reg - 5'h01;
                if (cnt_reg == 5'h01) begin
                    cmd_cs_next = 1'b0;
                    ctl_cs_next = 1'b0;
                    oe_next = 1'b0;
                    done_next = 1'b1;
                    state_next = pird_pkg::ST_IDLE;
                end
            end
            pird_pkg::ST_FINISH: begin
                if (side_reg && !side_wr_reg) begin
                    rdata_next = {side_rdata, 24'h000000};
                end
                done_next = 1'b1;
                state_next = pird_pkg::ST_IDLE;
            end
            default: begin
                state_next = pird_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= pird_pkg::ST_IDLE;
            cnt_reg <= 5'h00;
            recov_reg <= 5'h00;
            strobe_reg <= 5'h00;
            cmd_cs_reg <= 1'b0;
            ctl_cs_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            oe_reg <= 1'b0;
            da_reg <= 3'h0;
            dout_reg <= 16'h0000;
            lane_reg <= 2'h0;
            shadow_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            side_reg <= 1'b0;
            side_wr_reg <= 1'b0;
            side_wd_reg <= 8'h00;
            iordy_wait_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            recov_reg <= recov_next;
            strobe_reg <= strobe_next;
            cmd_cs_reg <= cmd_cs_next;
            ctl_cs_reg <= ctl_cs_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            oe_reg <= oe_next;
            da_reg <= da_next;
            dout_reg <= dout_next;
            lane_reg <= lane_next;
            shadow_reg <= shadow_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            side_reg <= side_next;
            side_wr_reg <= side_wr_next;
            side_wd_reg <= side_wd_next;
            iordy_wait_reg <= iordy_wait_next;
            rdy_reg <= rdy_next;
        end
    end

    assign command_block_select_n = ~cmd_cs_reg;
    assign control_block_select_n = ~ctl_cs_reg;
    assign drive_addr = da_reg;
    assign drive_read_strobe_n = ~rd_reg;
    assign drive_write_strobe_n = ~wr_reg;
    assign drive_data_out = dout_reg;
    assign drive_data_oe = oe_reg;
    assign resp_done = done_reg;
    assign resp_rdata = rdata_reg;
    assign side_req = side_reg;
    assign side_write = side_wr_reg;
    assign side_wdata = side_wd_reg;
    assign drive_select = shadow_reg;
    // DMA to a sync-enabled drive uses sync timing
    assign dma_sync_mode = sync_dma_control_reg[shadow_reg];
    assign dma_sync_timing = sync_dma_timing_reg;

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_strobe_end;
        $fell(rd_reg | wr_reg);
    endsequence
    sequence s_shutdown;
        (cmd_cs_reg | ctl_cs_reg) && !rd_reg && !wr_reg;
    endsequence

    a_decode_gate: assert property (req_claim |-> io_space_enable)
        else $error("claim without I/O space enable");
    a_upper_zero: assert property (req_claim |-> upper_zero)
        else $error("claim with nonzero upper address");
    a_abort_lane: assert property (
        req_target_abort |=> state_reg == pird_pkg::ST_IDLE && !resp_done)
        else $error("aborted access started a cycle");
    a_side_fwd: assert property (take && side_hit |=>
        side_req && command_block_select_n && control_block_select_n
        ##1 resp_done)
        else $error("side bus forward wrong");
    a_sec_quiet: assert property (take && (sec_cmd || sec_ctl)
        && !pri_cmd && !pri_ctl && !abort_hit |=> command_block_select_n
        && control_block_select_n ##1 resp_done)
        else $error("secondary cycle touched connector");
    a_shadow_read: assert property (take && !req.write
        |=> $stable(shadow_reg))
        else $error("shadow changed on read");
    a_shutdown_hold: assert property (s_strobe_end |->
        s_shutdown[*2])
        else $error("select dropped before shutdown");
    logic fast_prev;
    assign fast_prev = (strobe_reg != pird_pkg::CMP_STROBE);
    a_cmd_strobe: assert property ($rose(rd_reg) && !fast_prev
        && da_reg != pird_pkg::OFS_DATA |-> rd_reg[*8])
        else $error("compatible strobe too short");
endmodule

// [pird_drive_model.sv]
// Behavioural drive on the single IDE connector, one register set shared by both drives
`timescale 1ns/1ps
module pird_drive_model (
    input wire logic ref_clk,
    input wire logic cmd_sel_n,
    input wire logic ctl_sel_n,
    input wire logic [2:0] drive_addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] ddo,
    input wire logic oe,
    input wire logic slow,
    output logic [15:0] ddi,
    output logic ready
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [3:0] idx;
    int wait_cnt = 0;
    assign idx = {~ctl_sel_n, drive_addr};
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
    end
    always @(posedge ref_clk) begin
        if (!wr_n && oe && !(cmd_sel_n && ctl_sel_n)) mem[idx] <= ddo;
        if (!rd_n) last <= mem[idx];
        wait_cnt <= (rd_n && wr_n) ? 0 : wait_cnt + 1;
    end
    // Released data lines show the inverse of the last value
    assign ddi = (!rd_n && !(cmd_sel_n && ctl_sel_n)) ? mem[idx] : ~last;
    // Slow drive holds its ready pin low early in each strobe
    assign ready = !slow || wait_cnt >= 4;
endmodule

// [pird_decode_test.sv]
// Self-checking bench for the IDE register decode block
`timescale 1ns/1ps
module pird_decode_test;
    localparam logic [31:0] PC = {16'h0000, pird_pkg::PRI_CMD_BASE};
    localparam logic [31:0] SC = {16'h0000, pird_pkg::SEC_CMD_BASE};
    localparam logic [31:0] TC = {16'h0000, pird_pkg::PRI_CTL_BASE};
    localparam logic [31:0] UC = {16'h0000, pird_pkg::SEC_CTL_BASE};
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic io_en = 1'b0, pri_en = 1'b0, sec_en = 1'b0;
    pird_pkg::pird_tim_t tim = '0;
    pird_pkg::pird_sidtim_t stim = '0;
    logic [1:0] sdc = 2'h0, sdt = 2'h0;
    logic req_valid = 1'b0, slow = 1'b0;
    pird_pkg::pird_req_t req = '0;
    logic [7:0] side_rdata = 8'h00, side_wdata, side_wd;
    logic req_ready, req_claim, req_target_abort, resp_done;
    logic [31:0] resp_rdata, a;
    logic cmd_sel_n, ctl_sel_n, rd_n, wr_n, oe, ready;
    logic [2:0] drive_addr;
    logic [15:0] ddi, ddo;
    logic side_req, side_write, drive_select, dma_sync_mode;
    logic [1:0] dma_sync_timing;
    logic [3:0] b;
    logic [2:0] k;
    int fails = 0, n_tests = 0, low_cnt = 0, width = 0, tail = 0;
    logic struck, cmd_seen, ctl_seen, side_seen, exp_sel = 1'b0;
    logic [15:0] mirror [16] = '{default: 16'h0000};
    logic [31:0] sweep [9] = '{PC, PC + 4, PC + 8, PC - 4, TC, TC + 4, SC,
                               UC, PC | 32'h0001_0000};
    logic [3:0] ctl_be [6] = '{4'h4, 4'h8, 4'hc, 4'hf, 4'h1, 4'h2};

    pird_decode u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .io_space_enable(io_en), .primary_decode_enable(pri_en),
        .secondary_decode_enable(sec_en), .primary_timing_reg(tim),
        .second_drive_timing_reg(stim), .sync_dma_control_reg(sdc),
        .sync_dma_timing_reg(sdt), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .req_claim(req_claim),
        .req_target_abort(req_target_abort), .resp_done(resp_done),
        .resp_rdata(resp_rdata), .command_block_select_n(cmd_sel_n),
        .control_block_select_n(ctl_sel_n), .drive_addr(drive_addr),
        .drive_read_strobe_n(rd_n), .drive_write_strobe_n(wr_n),
        .drive_data_in(ddi), .drive_data_out(ddo), .drive_data_oe(oe),
        .drive_ready_in(ready), .side_req(side_req),
        .side_write(side_write), .side_wdata(side_wdata),
        .side_rdata(side_rdata), .drive_select(drive_select),
        .dma_sync_mode(dma_sync_mode), .dma_sync_timing(dma_sync_timing));

    pird_drive_model u_drive (.ref_clk(ref_clk), .cmd_sel_n(cmd_sel_n),
        .ctl_sel_n(ctl_sel_n), .drive_addr(drive_addr), .rd_n(rd_n),
        .wr_n(wr_n), .ddo(ddo), .oe(oe), .slow(slow), .ddi(ddi),
        .ready(ready));

    always #2.5 ref_clk = ~ref_clk;

    // Strobe width and select hold in whole clocks
    always @(posedge ref_clk) begin
        if (!rd_n || !wr_n) begin
            low_cnt++;
            tail = 0;
            struck = 1'b1;
        end else begin
            if (low_cnt != 0) width = low_cnt;
            low_cnt = 0;
            if (struck && !(cmd_sel_n && ctl_sel_n)) tail++;
        end
        if (!cmd_sel_n) cmd_seen = 1'b1;
        if (!ctl_sel_n) ctl_seen = 1'b1;
        if (side_req) side_seen = 1'b1;
        if (side_req && side_write) side_wd = side_wdata;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Bit 0 command, bit 1 control, bit 2 secondary
    function automatic logic [2:0] kind(input logic [31:0] x);
        logic [15:0] lo;
        lo = x[15:0];
        kind = 3'h0;
        if (x[31:16] == 16'h0000 && io_en) begin
            if (pri_en && lo[15:3] == PC[15:3]) kind = 3'h1;
            if (pri_en && lo[15:2] == TC[15:2]) kind = 3'h2;
            if (sec_en && lo[15:3] == SC[15:3]) kind = 3'h5;
            if (sec_en && lo[15:2] == UC[15:2]) kind = 3'h6;
        end
    endfunction

    function automatic int exp_w(input logic dr);
        if (!(dr ? tim.time1 : tim.time0)) return pird_pkg::CMPD_STROBE;
        if (dr && tim.sitre) return pird_pkg::ENH_STROBE_MIN + stim.isp;
        return pird_pkg::ENH_STROBE_MIN + tim.isp;
    endfunction

    // Sole PCI master, issues no bus-master DMA
    task automatic op(input logic [31:0] x, input logic [3:0] be,
                      input logic w, input logic [31:0] d);
        logic [2:0] kk;
        logic ea;
        logic [1:0] ln;
        logic [3:0] ofs;
        int n;
        kk = kind(x);
        ea = kk[1] && be[2] && be[3];
        ln = be[0] ? 2'h0 : be[1] ? 2'h1 : be[2] ? 2'h2 : 2'h3;
        ofs = kk[1] ? {2'h2, ln} : {1'b0, x[2], ln};
        struck = 1'b0;
        cmd_seen = 1'b0;
        ctl_seen = 1'b0;
        side_seen = 1'b0;
        @(negedge ref_clk);
        req <= '{addr: x, be: be, write: w, wdata: d};
        req_valid <= 1'b1;
        #1;
        check(req_claim, |kk, "claim");
        check(req_target_abort, ea, "abort");
        @(negedge ref_clk);
        req_valid <= 1'b0;
        n = 0;
        while (|kk && !ea && resp_done !== 1'b1 && n < 500) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 500) fails++;
        if (|kk && !ea && kk[2]) begin
            check(resp_rdata, 32'h0, "secondary rdata");
            check(cmd_seen | ctl_seen, 1'b0, "secondary pins");
        end else if (|kk && !ea && kk[1] && ln == 2'h3) begin
            check(side_seen, 1'b1, "side request");
            check(cmd_seen | ctl_seen, 1'b0, "side pins");
            if (w) check(side_wd, d[31:24], "side wdata");
            else check(resp_rdata[31:24], side_rdata, "side rdata");
        end else if (|kk && !ea && ofs != 4'h8 && ofs != 4'h9) begin
            check(kk[0] ? cmd_seen & !ctl_seen : ctl_seen & !cmd_seen,
                  1'b1, "select");
            check(tail >= 2, 1'b1, "select hold");
            if (w) mirror[ofs] = (ofs == 0) ? d[15:0] : {8'h00, d[8*ln +: 8]};
            else if (ofs == 0)
                check(resp_rdata[15:0], mirror[0], "data");
            else
                check(resp_rdata[8*ln +: 8], mirror[ofs][7:0], "byte");
            if (w && ofs == 4'h6) exp_sel = d[8*ln+4];
        end
        check(drive_select, exp_sel, "drive select");
    endtask

    initial begin
        void'($urandom(1));
        repeat (10) @(posedge ref_clk);
        #1;
        check({cmd_sel_n, ctl_sel_n, rd_n, wr_n, req_ready, resp_done},
              6'h3e, "reset state");
        @(negedge ref_clk);
        arst_n = 1'b1;
        for (int e = 0; e < 8; e++) begin
            @(negedge ref_clk);
            {io_en, pri_en, sec_en} = e[2:0];
            foreach (sweep[i]) op(sweep[i], 4'h2, 1'b0, 32'h0);
        end
        for (int i = 0; i < 12; i++) begin
            @(negedge ref_clk);
            tim = 9'($urandom);
            stim = 4'($urandom);
            sdc = 2'($urandom);
            sdt = 2'($urandom);
            tim.ie0 = 1'b0;
            tim.ie1 = 1'b0;
            op(PC + 4, 4'h4, 1'b1, {11'h0, i[0], 20'h0});
            check(width, pird_pkg::CMP_STROBE, "cmd strobe");
            check(dma_sync_mode, sdc[i[0]], "sync mode");
            check(dma_sync_timing, sdt, "sync timing");
            op(PC, 4'h3, i[1], $urandom);
            check(width, exp_w(i[0]), "data strobe");
        end
        @(negedge ref_clk);
        tim = '0;
        tim.time0 = 1'b1;
        tim.ie0 = 1'b1;
        slow = 1'b1;
        op(PC + 4, 4'h4, 1'b1, 32'h0);
        op(PC, 4'h3, 1'b1, 32'h1234);
        check(width > 3, 1'b1, "ready wait");
        @(negedge ref_clk);
        tim.ie0 = 1'b0;
        op(PC, 4'h3, 1'b1, 32'h5678);
        check(width, pird_pkg::ENH_STROBE_MIN, "ready masked");
        @(negedge ref_clk);
        slow = 1'b0;
        foreach (ctl_be[i]) begin
            @(negedge ref_clk);
            side_rdata = 8'($urandom);
            op(TC, ctl_be[i], 1'b1, $urandom);
            op(TC, ctl_be[i], 1'b0, 32'h0);
            op(UC, ctl_be[i], 1'b0, 32'h0);
        end
        for (int i = 0; i < 80; i++) begin
            @(negedge ref_clk);
            tim = 9'($urandom);
            stim = 4'($urandom);
            slow = 1'($urandom);
            side_rdata = 8'($urandom);
            a = sweep[$urandom % 9];
            k = kind(a);
            // Data port as 16 bits, other registers one byte, primary control block any byte enables half the time
            b = 4'h1 << ($urandom % 4);
            if (k == 3'h2 && $urandom % 2) b = 4'($urandom % 15 + 1);
            if (b == 4'h1 && k[0] && !a[2]) b = 4'h3;
            op(a, b, 1'($urandom), $urandom);
        end
        end_of_test;
    end

    initial begin
        #(5 * 60000);
        fails++;
        end_of_test;
    end
endmodule
